// >>> verilog/bsc_link_pkg.sv
// constants, types and helper functions for the bsc character link
package bsc_link_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses, one 32-bit word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_TX_DATA = 8'h08;
	localparam logic [7:0] ADDR_RX_DATA = 8'h0C;
	localparam logic [7:0] ADDR_SUPPRESS = 8'h10;
	localparam logic [7:0] ADDR_BCC = 8'h14;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRL_CODE_LSB = 0;
	localparam int CTRL_CRC_BIT = 2;
	localparam int CTRL_TX_EN_BIT = 3;
	localparam int CTRL_RX_EN_BIT = 4;
	localparam int CTRL_INVERT_BIT = 5;
	localparam int CTRL_MSB_BIT = 6;
	localparam int CTRL_DROP_BIT = 8;
	localparam int CTRL_BCC_CLR_BIT = 9;
	localparam int STAT_OVERRUN_BIT = 3;
	localparam int STAT_PERR_BIT = 4;
	localparam int TX_RAW_BIT = 8;
	localparam int SUPP_IDLE_BIT = 0;
	localparam int SUPP_NULL_BIT = 1;
	localparam int SUPP_CTL_BIT = 2;
	localparam int SUPP_TEXT_BIT = 3;

	// ----------------------------------------------------------------
	// reset values and counts
	// ----------------------------------------------------------------
	localparam logic [6:0] CTRL_RESET = 7'h00;
	localparam logic [3:0] SUPP_RESET = 4'h0;
	localparam logic [1:0] TX_MIN_SYNC = 2'h2;
	localparam int LINE_RATE_MIN_BPS = 50;
	localparam int LINE_RATE_MAX_BPS = 64000;

	// ----------------------------------------------------------------
	// codes, characters and states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CODE_ASCII7 = 2'b00,
		CODE_ASCII8 = 2'b01,
		CODE_EBCDIC = 2'b10,
		CODE_TRANSCODE = 2'b11
	} code_t;

	typedef enum logic [1:0] {
		BCC_LRC = 2'b00,
		BCC_CRC16 = 2'b01,
		BCC_CRC12 = 2'b10
	} bcc_mode_t;

	typedef enum logic [1:0] {
		RX_HUNT = 2'b00,
		RX_SYNC1 = 2'b01,
		RX_FRAMED = 2'b10
	} rx_state_t;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_SYNC = 2'b01,
		TX_DATA = 2'b10
	} tx_state_t;

	localparam logic [7:0] SYNC_EBCDIC = 8'h32;
	localparam logic [7:0] SYNC_ASCII = 8'h16;
	localparam logic [7:0] SYNC_TRANSCODE = 8'h3A;
	localparam logic [7:0] CHAR_NULL = 8'h00;
	localparam logic [7:0] EBCDIC_TEXT_MIN = 8'h40;
	localparam logic [15:0] CRC16_POLY_REFL = 16'hA001;
	localparam logic [11:0] CRC12_POLY_REFL = 12'hF01;

	function automatic logic [7:0] sync_char(input logic [1:0] code);
		case (code)
			CODE_EBCDIC: sync_char = SYNC_EBCDIC;
			CODE_TRANSCODE: sync_char = SYNC_TRANSCODE;
			default: sync_char = SYNC_ASCII;
		endcase
	endfunction : sync_char

	function automatic logic is_six(input logic [1:0] code);
		is_six = (code == CODE_TRANSCODE);
	endfunction : is_six

	function automatic logic [7:0] shift_in(input logic [7:0] sh,
		input logic b, input logic msb);
		shift_in = msb ? {sh[6:0], b} : {b, sh[7:1]};
	endfunction : shift_in

	function automatic logic [7:0] take_char(input logic [7:0] sh,
		input logic six, input logic msb);
		if (!six)
			take_char = sh;
		else
			take_char = msb ? {2'b00, sh[5:0]} : {2'b00, sh[7:2]};
	endfunction : take_char

endpackage : bsc_link_pkg

// >>> verilog/bcc_unit.sv
// block check accumulator: lrc, crc-16 or crc-12 over received chars
`timescale 1ns/10ps
module bcc_unit
	import bsc_link_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic char_stb,
	input wire logic [7:0] char_in,
	input wire logic six,
	input wire logic [1:0] mode,
	output logic [15:0] bcc
);

	logic [15:0] bcc_q;
	logic [15:0] bcc_d;

	// ----------------------------------------------------------------
	// accumulate one character, lsb first
	// ----------------------------------------------------------------
	always_comb begin
		logic fb;
		fb = 1'b0;
		bcc_d = clear ? 16'h0000 : bcc_q;
		if (char_stb) begin
			if (mode == BCC_LRC) begin
				bcc_d[7:0] = bcc_d[7:0] ^ char_in;
			end else begin
				for (int i = 0; i < 8; i++) begin
					if (!(six && i > 5)) begin
						fb = bcc_d[0] ^ char_in[i];
						bcc_d = bcc_d >> 1;
						if (mode == BCC_CRC12) begin
							if (fb)
								bcc_d[11:0] = bcc_d[11:0] ^ CRC12_POLY_REFL;
						end else if (fb) begin
							bcc_d = bcc_d ^ CRC16_POLY_REFL;
						end
					end
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			bcc_q <= 16'h0000;
		else
			bcc_q <= bcc_d;
	end

	assign bcc = bcc_q;

endmodule : bcc_unit

// >>> verilog/bsc_sync_char_link.sv
// bsc synchronous character link: avalon registers and serial line
// Summary of operation
// (RULE_01) odd parity for 7-bit ascii; none for ebcdic, transcode, 8-bit ascii.
// (RULE_02) transmitted characters carry the parity of the selected code.
// (RULE_03) raw transmit characters go out unchanged, parity untouched.
// (RULE_04) link is synchronous half-duplex; receiver idles while sending.
// (RULE_05) sync pair chosen from code: 32 ebcdic, 16 ascii, 3a transcode.
// (RULE_06) framing needs two consecutive syncs; transmitter sends two first.
// (RULE_07) block check lrc or crc-16, or lrc or crc-12 for transcode.
// (RULE_08) line clocked externally at any rate from 50 bps to 64 kbps.
// (RULE_09) suppressed characters are still stored, only flagged for display.
// (RULE_10) no zero-bit insertion or removal on either direction.
// (RULE_11) drop sync stops accepting characters and resumes sync hunting.
// (RULE_12) characters shift lsb first, uninverted, unless configured otherwise.
`timescale 1ns/10ps
module bsc_sync_char_link
	import bsc_link_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic line_clk,
	input wire logic rxd,
	output logic txd
);

	// ----------------------------------------------------------------
	// core domain state
	// ----------------------------------------------------------------
	logic [6:0] ctrl_q, ctrl_d;
	logic [3:0] supp_q, supp_d;
	logic [7:0] tx_hold_q, tx_hold_d;
	logic tx_req_q, tx_req_d;
	logic drop_tgl_q, drop_tgl_d;
	logic [7:0] rx_data_q, rx_data_d;
	logic rx_valid_q, rx_valid_d;
	logic rx_cperr_q, rx_cperr_d;
	logic rx_supp_q, rx_supp_d;
	logic overrun_q, overrun_d;
	logic perr_q, perr_d;
	logic wait_q, wait_d;
	logic [31:0] rdata_q, rdata_d;
	logic ack_m_q, ack_s_q;
	logic rxt_m_q, rxt_s_q, rxt_prev_q;
	logic ins_m_q, ins_s_q;
	logic [15:0] bcc_val;
	logic [1:0] code;
	logic [1:0] bmode;
	logic tx_pending, wr_fire, rd_fire, accept, rx_take, bcc_clear;
	logic [7:0] cur_sync;
	rx_state_t rx_st_q, rx_st_d;
	tx_state_t tx_st_q, tx_st_d;
	logic [7:0] rx_sh_q, rx_sh_d, rx_word_q, rx_word_d;
	logic [7:0] tx_sh_q, tx_sh_d;
	logic [2:0] rx_cnt_q, rx_cnt_d, tx_cnt_q, tx_cnt_d;
	logic [1:0] tx_syncs_q, tx_syncs_d;
	logic rx_tgl_q, rx_tgl_d, in_sync_q, in_sync_d;
	logic tx_ack_q, tx_ack_d, txd_q, txd_d, drop_prev_d;

	assign code = ctrl_q[CTRL_CODE_LSB +: 2];
	assign tx_pending = (tx_req_q != ack_s_q);
	assign wr_fire = avs_write && !wait_q;
	assign rd_fire = avs_read && !wait_q;
	// a pending character stalls a further transmit write
	assign accept = wait_q && (avs_read || avs_write) &&
		!(avs_write && avs_address == ADDR_TX_DATA && tx_pending);
	// no capture while the receive word is being read out
	assign rx_take = (rxt_s_q != rxt_prev_q) &&
		!(avs_read && avs_address == ADDR_RX_DATA);
	assign bcc_clear = wr_fire && avs_address == ADDR_CTRL &&
		avs_writedata[CTRL_BCC_CLR_BIT];
	assign cur_sync = sync_char(code);

	// crc-16 not legal with transcode, crc-12 only with transcode
	assign bmode = !ctrl_q[CTRL_CRC_BIT] ? BCC_LRC :
		(is_six(code) ? BCC_CRC12 : BCC_CRC16); // see RULE_07

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] add_parity(input logic [1:0] c,
		input logic [7:0] d);
		if (c == CODE_ASCII7)
			add_parity = {~^d[6:0], d[6:0]}; // see RULE_01
		else
			add_parity = d; // see RULE_01
	endfunction : add_parity

	function automatic logic suppressed(input logic [3:0] s,
		input logic [1:0] c, input logic [7:0] ch, input logic [7:0] sy);
		logic ctl;
		ctl = (c == CODE_EBCDIC) ? (ch < EBCDIC_TEXT_MIN) :
			(ch[6:5] == 2'b00);
		if (ch == sy)
			suppressed = s[SUPP_IDLE_BIT];
		else if (ch == CHAR_NULL)
			suppressed = s[SUPP_NULL_BIT];
		else if (ctl)
			suppressed = s[SUPP_CTL_BIT];
		else
			suppressed = s[SUPP_TEXT_BIT];
	endfunction : suppressed

	// ----------------------------------------------------------------
	// register slave
	// ----------------------------------------------------------------
	always_comb begin
		ctrl_d = ctrl_q;
		supp_d = supp_q;
		tx_hold_d = tx_hold_q;
		tx_req_d = tx_req_q;
		drop_tgl_d = drop_tgl_q;
		rx_data_d = rx_data_q;
		rx_valid_d = rx_valid_q;
		rx_cperr_d = rx_cperr_q;
		rx_supp_d = rx_supp_q;
		overrun_d = overrun_q;
		perr_d = perr_q;
		wait_d = 1'b1;
		rdata_d = rdata_q;
		if (accept) begin
			wait_d = 1'b0;
			rdata_d = 32'h0000_0000;
			if (avs_read) begin
				case (avs_address)
					ADDR_CTRL: rdata_d = {25'h000_0000, ctrl_q};
					ADDR_STATUS: rdata_d = {27'h000_0000, perr_q, overrun_q,
						rx_valid_q, tx_pending, ins_s_q};
					ADDR_TX_DATA: rdata_d = {24'h00_0000, tx_hold_q};
					ADDR_RX_DATA: rdata_d = {21'h00_0000, rx_supp_q,
						rx_cperr_q, rx_valid_q, rx_data_q};
					ADDR_SUPPRESS: rdata_d = {28'h000_0000, supp_q};
					ADDR_BCC: rdata_d = {16'h0000, bcc_val};
					default: rdata_d = 32'h0000_0000;
				endcase
			end
		end
		if (wr_fire) begin
			case (avs_address)
				ADDR_CTRL: begin
					ctrl_d = avs_writedata[6:0];
					if (avs_writedata[CTRL_DROP_BIT])
						drop_tgl_d = ~drop_tgl_q; // see RULE_11
				end
				ADDR_STATUS: begin
					if (avs_writedata[STAT_OVERRUN_BIT])
						overrun_d = 1'b0;
					if (avs_writedata[STAT_PERR_BIT])
						perr_d = 1'b0;
				end
				ADDR_TX_DATA: begin
					if (avs_writedata[TX_RAW_BIT])
						tx_hold_d = avs_writedata[7:0]; // see RULE_03
					else
						tx_hold_d = add_parity(code,
							avs_writedata[7:0]); // see RULE_02
					tx_req_d = ~tx_req_q;
				end
				ADDR_SUPPRESS: supp_d = avs_writedata[3:0];
				default: begin
				end
			endcase
		end
		if (rd_fire && avs_address == ADDR_RX_DATA)
			rx_valid_d = 1'b0;
		// capture comes last so a new event wins over a clear
		if (rx_take) begin
			rx_data_d = rx_word_q;
			rx_valid_d = 1'b1;
			// every character is stored; suppression is only a flag
			rx_supp_d = suppressed(supp_q, code, rx_word_q,
				cur_sync); // see RULE_09
			rx_cperr_d = (code == CODE_ASCII7) && !(^rx_word_q); // see RULE_01
			if (code == CODE_ASCII7 && !(^rx_word_q))
				perr_d = 1'b1;
			if (rx_valid_q && !(rd_fire && avs_address == ADDR_RX_DATA))
				overrun_d = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl_q <= CTRL_RESET;
			supp_q <= SUPP_RESET;
			tx_hold_q <= 8'h00;
			tx_req_q <= 1'b0;
			drop_tgl_q <= 1'b0;
			rx_data_q <= 8'h00;
			rx_valid_q <= 1'b0;
			rx_cperr_q <= 1'b0;
			rx_supp_q <= 1'b0;
			overrun_q <= 1'b0;
			perr_q <= 1'b0;
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			ctrl_q <= ctrl_d;
			supp_q <= supp_d;
			tx_hold_q <= tx_hold_d;
			tx_req_q <= tx_req_d;
			drop_tgl_q <= drop_tgl_d;
			rx_data_q <= rx_data_d;
			rx_valid_q <= rx_valid_d;
			rx_cperr_q <= rx_cperr_d;
			rx_supp_q <= rx_supp_d;
			overrun_q <= overrun_d;
			perr_q <= perr_d;
			wait_q <= wait_d;
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// line to core synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ack_m_q <= 1'b0;
			ack_s_q <= 1'b0;
			rxt_m_q <= 1'b0;
			rxt_s_q <= 1'b0;
			rxt_prev_q <= 1'b0;
			ins_m_q <= 1'b0;
			ins_s_q <= 1'b0;
		end else begin
			ack_m_q <= tx_ack_q;
			ack_s_q <= ack_m_q;
			rxt_m_q <= rx_tgl_q;
			rxt_s_q <= rxt_m_q;
			if (rx_take)
				rxt_prev_q <= rxt_s_q;
			ins_m_q <= in_sync_q;
			ins_s_q <= ins_m_q;
		end
	end

	bcc_unit u_bcc (
		.core_clk(core_clk),
		.rst(rst),
		.clear(bcc_clear),
		.char_stb(rx_take),
		.char_in(rx_word_q),
		.six(is_six(code)),
		.mode(bmode),
		.bcc(bcc_val)
	);

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;

	// ----------------------------------------------------------------
	// line domain: synchronisers
	// ----------------------------------------------------------------
	// the line clock sets the bit rate; nothing here limits it
	// within the supported range, and no bits are stuffed
	logic lrst_m_q, lrst_q;
	logic rxd_m_q, rxd_s_q;
	logic [5:0] cfg_m_q, cfg_s_q;
	logic drop_m_q, drop_s_q, drop_prev_q;
	logic txr_m_q, txr_s_q;
	logic [1:0] l_code;
	logic l_tx_en, l_rx_en, l_inv, l_msb, l_six;

	always_ff @(posedge line_clk) begin
		lrst_m_q <= rst;
		lrst_q <= lrst_m_q;
		rxd_m_q <= rxd; // see RULE_08
		rxd_s_q <= rxd_m_q;
		cfg_m_q <= {ctrl_q[CTRL_MSB_BIT], ctrl_q[CTRL_INVERT_BIT],
			ctrl_q[CTRL_RX_EN_BIT], ctrl_q[CTRL_TX_EN_BIT], code};
		cfg_s_q <= cfg_m_q;
		drop_m_q <= drop_tgl_q;
		drop_s_q <= drop_m_q;
		txr_m_q <= tx_req_q;
		txr_s_q <= txr_m_q;
	end

	assign l_code = cfg_s_q[1:0];
	assign l_tx_en = cfg_s_q[2];
	assign l_rx_en = cfg_s_q[3];
	assign l_inv = cfg_s_q[4]; // see RULE_12
	assign l_msb = cfg_s_q[5]; // see RULE_12
	assign l_six = is_six(l_code);

	// ----------------------------------------------------------------
	// line domain: receiver and transmitter
	// ----------------------------------------------------------------

	always_comb begin
		logic [7:0] sh_n;
		logic [7:0] ch;
		logic [7:0] sy;
		logic [2:0] last;
		sy = sync_char(l_code); // see RULE_05
		last = l_six ? 3'd5 : 3'd7;
		sh_n = shift_in(rx_sh_q, rxd_s_q ^ l_inv, l_msb); // see RULE_12
		ch = take_char(sh_n, l_six, l_msb);
		rx_st_d = rx_st_q;
		rx_sh_d = sh_n; // see RULE_10
		rx_cnt_d = rx_cnt_q + 3'd1;
		rx_word_d = rx_word_q;
		rx_tgl_d = rx_tgl_q;
		drop_prev_d = drop_s_q;
		case (rx_st_q)
			RX_HUNT: begin
				rx_cnt_d = 3'd0;
				if (ch == sy)
					rx_st_d = RX_SYNC1;
			end
			RX_SYNC1: begin
				if (rx_cnt_q == last) begin
					rx_cnt_d = 3'd0;
					// second sync in a row gains framing
					rx_st_d = (ch == sy) ? RX_FRAMED : RX_HUNT; // see RULE_06
				end
			end
			RX_FRAMED: begin
				if (rx_cnt_q == last) begin
					rx_cnt_d = 3'd0;
					rx_word_d = ch;
					rx_tgl_d = ~rx_tgl_q;
				end
			end
			default: rx_st_d = RX_HUNT;
		endcase
		if (drop_s_q != drop_prev_q)
			rx_st_d = RX_HUNT; // see RULE_11
		if (!l_rx_en || tx_st_q != TX_IDLE)
			rx_st_d = RX_HUNT; // see RULE_04
		in_sync_d = (rx_st_d == RX_FRAMED);

		tx_st_d = tx_st_q;
		tx_sh_d = tx_sh_q;
		tx_cnt_d = tx_cnt_q;
		tx_syncs_d = tx_syncs_q;
		tx_ack_d = tx_ack_q;
		txd_d = 1'b1;
		case (tx_st_q)
			TX_IDLE: begin
				if (l_tx_en) begin
					tx_st_d = TX_SYNC;
					tx_sh_d = sy;
					tx_cnt_d = 3'd0;
					tx_syncs_d = 2'd1;
				end
			end
			TX_SYNC, TX_DATA: begin
				txd_d = (l_msb ? tx_sh_q[last] : tx_sh_q[0]) ^ l_inv; // see RULE_12
				tx_sh_d = l_msb ? {tx_sh_q[6:0], 1'b0} : {1'b0, tx_sh_q[7:1]};
				tx_cnt_d = tx_cnt_q + 3'd1;
				if (tx_cnt_q == last) begin
					tx_cnt_d = 3'd0;
					if (!l_tx_en) begin
						tx_st_d = TX_IDLE;
					end else if (tx_syncs_q < TX_MIN_SYNC) begin
						tx_sh_d = sy; // see RULE_06
						tx_syncs_d = tx_syncs_q + 2'd1;
					end else if (txr_s_q != tx_ack_q) begin
						tx_sh_d = tx_hold_q;
						tx_ack_d = ~tx_ack_q;
						tx_st_d = TX_DATA;
					end else begin
						tx_sh_d = sy;
						tx_st_d = TX_SYNC;
					end
				end
			end
			default: tx_st_d = TX_IDLE;
		endcase
	end

	always_ff @(posedge line_clk) begin
		if (lrst_q) begin
			rx_st_q <= RX_HUNT;
			rx_sh_q <= 8'h00;
			rx_cnt_q <= 3'd0;
			rx_word_q <= 8'h00;
			rx_tgl_q <= 1'b0;
			in_sync_q <= 1'b0;
			drop_prev_q <= 1'b0;
			tx_st_q <= TX_IDLE;
			tx_sh_q <= 8'h00;
			tx_cnt_q <= 3'd0;
			tx_syncs_q <= 2'd0;
			tx_ack_q <= 1'b0;
			txd_q <= 1'b1;
		end else begin
			rx_st_q <= rx_st_d;
			rx_sh_q <= rx_sh_d;
			rx_cnt_q <= rx_cnt_d;
			rx_word_q <= rx_word_d;
			rx_tgl_q <= rx_tgl_d;
			in_sync_q <= in_sync_d;
			drop_prev_q <= drop_prev_d;
			tx_st_q <= tx_st_d;
			tx_sh_q <= tx_sh_d;
			tx_cnt_q <= tx_cnt_d;
			tx_syncs_q <= tx_syncs_d;
			tx_ack_q <= tx_ack_d;
			txd_q <= txd_d;
		end
	end

	assign txd = txd_q;

endmodule : bsc_sync_char_link

// >>> dv/bsc_link_properties.sv
// concurrent checks on the bsc link top ports
`timescale 1ns/10ps
module bsc_link_checker
	import bsc_link_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic line_clk,
	input wire logic rxd,
	input wire logic txd
);
	// ----------------------------------------------------------------
	// shadow of written settings
	// ----------------------------------------------------------------
	logic rd_done;
	logic wr_done;
	logic rx_rd;
	logic mapped;
	logic [1:0] code;
	logic [6:0] ctrl_q;
	logic [6:0] ctrl_d;
	logic [3:0] supp_q;
	logic [3:0] supp_d;
	logic [7:0] age_q;
	logic [7:0] age_d;
	logic [7:0] sync_v;
	assign rd_done = avs_read && !avs_waitrequest;
	assign wr_done = avs_write && !avs_waitrequest;
	assign rx_rd = rd_done && avs_address == ADDR_RX_DATA && avs_readdata[8];
	assign mapped = avs_address inside {ADDR_CTRL, ADDR_STATUS,
		ADDR_TX_DATA, ADDR_RX_DATA, ADDR_SUPPRESS, ADDR_BCC};
	assign code = ctrl_q[1:0];
	assign sync_v = code == CODE_EBCDIC ? 8'h32 :
		(code == CODE_TRANSCODE ? 8'h3a : 8'h16);
	always_comb begin
		ctrl_d = ctrl_q;
		supp_d = supp_q;
		age_d = ctrl_q[3] ? age_q + {7'h00, age_q != 8'hff} : 8'h00;
		if (wr_done && avs_address == ADDR_CTRL)
			ctrl_d = avs_writedata[6:0];
		if (wr_done && avs_address == ADDR_SUPPRESS)
			supp_d = avs_writedata[3:0];
		if (rst) begin
			ctrl_d = CTRL_RESET;
			supp_d = SUPP_RESET;
			age_d = 8'h00;
		end
	end
	always_ff @(posedge core_clk) begin
		ctrl_q <= ctrl_d;
		supp_q <= supp_d;
		age_q <= age_d;
	end
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_wait_one;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one)
		else $error("waitrequest low for more than one cycle");
	property p_ctrl_back;
		rd_done && avs_address == ADDR_CTRL |->
			avs_readdata == {25'h000_0000, ctrl_q};
	endproperty
	a_ctrl_back: assert property (p_ctrl_back)
		else $error("control readback differs from written value");
	property p_unmapped;
		rd_done && !mapped |-> avs_readdata == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read returned nonzero");
	property p_par_odd;
		rx_rd && code == CODE_ASCII7 |->
			avs_readdata[9] == ~^avs_readdata[7:0];
	endproperty
	a_par_odd: assert property (p_par_odd)
		else $error("odd parity flag wrong");
	property p_par_none;
		rx_rd && code != CODE_ASCII7 |-> !avs_readdata[9];
	endproperty
	a_par_none: assert property (p_par_none)
		else $error("parity flag set for code without parity");
	property p_supp_zero;
		rx_rd && supp_q == 4'h0 |-> !avs_readdata[10];
	endproperty
	a_supp_zero: assert property (p_supp_zero)
		else $error("suppress flag with suppression off");
	property p_supp_idle;
		rx_rd && supp_q[SUPP_IDLE_BIT] && avs_readdata[7:0] == sync_v |->
			avs_readdata[10];
	endproperty
	a_supp_idle: assert property (p_supp_idle)
		else $error("stored idle char not flagged");
	property p_half_duplex;
		rd_done && avs_address == ADDR_STATUS && age_q == 8'hff |->
			!avs_readdata[0];
	endproperty
	a_half_duplex: assert property (p_half_duplex)
		else $error("receiver framed while transmitting");
endmodule : bsc_link_checker

bind bsc_sync_char_link bsc_link_checker bsc_link_checker_i (
	.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .line_clk(line_clk), .rxd(rxd),
	.txd(txd));

// >>> dv/line_partner.sv
// far-side station: serial stimulus on rxd, char capture from txd
`timescale 1ns/10ps
module line_partner (
	input wire logic line_clk,
	input wire logic txd,
	input wire logic [7:0] sync_sel,
	output logic rxd
);
	logic [15:0] hist = 16'h0000;
	logic framed = 1'b0;
	logic flip = 1'b0;
	logic msb = 1'b0;
	int nbit = 0;
	logic [7:0] got[$];
	initial rxd = 1'b1;
	// ----------------------------------------------------------------
	// capture: framing on a sync pair, fill syncs dropped
	// ----------------------------------------------------------------
	always @(posedge line_clk) begin
		hist = {txd, hist[15:1]};
		nbit = nbit + 1;
		if (!framed && hist == {sync_sel, sync_sel}) begin
			framed = 1'b1;
			nbit = 0;
		end else if (framed && nbit == 8) begin
			nbit = 0;
			if (hist[15:8] == 8'hff)
				framed = 1'b0;
			else if (hist[15:8] != sync_sel)
				got.push_back(hist[15:8]);
		end
	end
	// ----------------------------------------------------------------
	// stimulus: lsb first unless msb is set, mark when idle
	// ----------------------------------------------------------------
	task automatic send_char(input logic [7:0] c, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge line_clk);
			rxd <= (msb ? c[n - 1 - i] : c[i]) ^ flip;
		end
	endtask : send_char
	task automatic idle();
		@(posedge line_clk);
		rxd <= 1'b1;
	endtask : idle
endmodule : line_partner

// >>> dv/tb_top.sv
// self-checking bench for the bsc character link
`timescale 1ns/10ps
`define CHK(nm, e, g) \
	begin \
		n_compared++; \
		if ((g) !== (e)) begin \
			n_mismatch++; \
			$display("[ERR] %s expected %h seen %h", nm, e, g); \
		end \
	end
module tb_top;
	import bsc_link_pkg::*;
	logic core_clk = 1'b0;
	logic line_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic rxd;
	logic txd;
	logic [7:0] sync_sel = 8'h16;
	logic [31:0] rdq;
	int n_mismatch = 0;
	int n_compared = 0;
	int seed = 32'hd559_3898;
	initial forever #10 core_clk = ~core_clk;
	initial begin
		#7;
		forever #80 line_clk = ~line_clk;
	end
	bsc_sync_char_link bsc_sync_char_link_i (.core_clk(core_clk), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.line_clk(line_clk), .rxd(rxd), .txd(txd));
	line_partner line_partner_i (.line_clk(line_clk), .txd(txd),
		.sync_sel(sync_sel), .rxd(rxd));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic final_report();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report
	task automatic limit(input int n, input int top);
		if (n >= top) begin
			n_mismatch++;
			$display("[ERR] wait bound expected %0d seen %0d", top, n);
			final_report();
		end
	endtask : limit
	task automatic access(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 5000);
		rdq = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge core_clk);
		limit(n, 5000);
	endtask : access
	task automatic poll(input logic [7:0] a, input int b, input logic v);
		int n;
		n = 0;
		do begin
			access(1'b0, a, 32'h0000_0000);
			n++;
		end while (rdq[b] !== v && n < 2000);
		limit(n, 2000);
	endtask : poll
	function automatic logic [7:0] exp_sync(input logic [1:0] c);
		exp_sync = c == 2'h2 ? 8'h32 : (c == 2'h3 ? 8'h3a : 8'h16);
	endfunction : exp_sync
	function automatic logic [7:0] exp_tx(input logic [1:0] c,
		input logic [7:0] d, input logic raw);
		exp_tx = (raw || c != 2'h0) ? d : {~^d[6:0], d[6:0]};
	endfunction : exp_tx
	function automatic logic [31:0] exp_bcc(input logic [7:0] d,
		input int k);
		logic [15:0] r;
		logic [15:0] p;
		r = k[0] ? 16'h0000 : {8'h00, d};
		p = (k == 3) ? {4'h0, CRC12_POLY_REFL} : CRC16_POLY_REFL;
		for (int i = 0; k[0] && i < ((k == 3) ? 6 : 8); i++)
			r = (r >> 1) ^ ((r[0] ^ d[i]) ? p : 16'h0000);
		exp_bcc = {16'h0000, r};
	endfunction : exp_bcc
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] d;
		logic [1:0] c;
		int b;
		int n;
		logic [31:0] cw;
		logic [7:0] exp_q[$];
		repeat (40) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		access(1'b0, ADDR_CTRL, 32'h0000_0000);
		`CHK("ctrl reset", 32'h0000_0000, rdq)
		access(1'b1, ADDR_CTRL, 32'h0000_0363);
		access(1'b0, ADDR_CTRL, 32'h0000_0000);
		`CHK("ctrl readback", 32'h0000_0063, rdq)
		access(1'b1, 8'h18, 32'hffff_ffff);
		access(1'b0, 8'h18, 32'h0000_0000);
		`CHK("unmapped", 32'h0000_0000, rdq)
		for (int k = 0; k < 3; k++) begin
			c = k[1:0];
			sync_sel = exp_sync(c);
			access(1'b1, ADDR_CTRL, {24'h00_0000, 6'h06, c});
			repeat (4) line_partner_i.send_char(sync_sel, 8);
			line_partner_i.idle();
			for (int j = 0; j < 3; j++) begin
				d = ($random(seed) | 8'h40) & 8'hfe;
				if (j == 2)
					d[7] = ^d[6:0];
				exp_q.push_back(exp_tx(c, d, j == 2));
				access(1'b1, ADDR_TX_DATA, {23'h00_0000, j == 2, d});
			end
			poll(ADDR_STATUS, 1, 1'b0);
			access(1'b1, ADDR_CTRL, {30'h0000_0000, c});
			n = 0;
			while ((line_partner_i.got.size() < 3 ||
				line_partner_i.framed) && n < 5000) begin
				@(posedge core_clk);
				n++;
			end
			limit(n, 5000);
			for (int j = 0; j < 3; j++)
				`CHK("tx char", exp_q[j], line_partner_i.got[j])
			exp_q.delete();
			line_partner_i.got.delete();
		end
		for (int k = 0; k < 4; k++) begin
			c = k[1:0];
			b = (c == 2'h3) ? 6 : 8;
			sync_sel = exp_sync(c);
			access(1'b1, ADDR_SUPPRESS, {31'h0000_0000, k != 0});
			line_partner_i.flip = (k == 1);
			line_partner_i.msb = (k == 2);
			cw = {22'h00_0000, 2'h2, 1'b0, k == 2, k == 1, 2'h2, k[0], c};
			access(1'b1, ADDR_CTRL, cw);
			d = $random(seed) | 8'h40;
			if (c == 2'h3)
				d = d & 8'h2f;
			fork
				begin
					line_partner_i.send_char(sync_sel, b);
					line_partner_i.send_char(8'h00, b);
					line_partner_i.send_char(sync_sel, b);
					line_partner_i.send_char(sync_sel, b);
					line_partner_i.send_char(d, b);
					line_partner_i.send_char(sync_sel, b);
					line_partner_i.idle();
				end
				begin
					poll(ADDR_RX_DATA, 8, 1'b1);
					`CHK("rx char", d, rdq[7:0])
					`CHK("rx parity", c == 2'h0 ? ~^d : 1'b0, rdq[9])
					access(1'b0, ADDR_BCC, 32'h0000_0000);
					`CHK("bcc", exp_bcc(d, k), rdq)
					poll(ADDR_RX_DATA, 8, 1'b1);
					`CHK("rx idle", {k != 0, sync_sel}, {rdq[10], rdq[7:0]})
				end
			join
			@(posedge core_clk);
			access(1'b0, ADDR_STATUS, 32'h0000_0000);
			`CHK("in sync", 1'b1, rdq[0])
			access(1'b1, ADDR_CTRL, cw ^ 32'h0000_0300);
			poll(ADDR_STATUS, 0, 1'b0);
			access(1'b0, ADDR_RX_DATA, 32'h0000_0000);
			access(1'b0, ADDR_RX_DATA, 32'h0000_0000);
			line_partner_i.send_char(8'h55, b);
			line_partner_i.send_char(8'h55, b);
			line_partner_i.idle();
			@(posedge core_clk);
			access(1'b0, ADDR_RX_DATA, 32'h0000_0000);
			`CHK("after drop", 1'b0, rdq[8])
		end
		final_report();
	end
endmodule : tb_top
